// ===== rtl/idx_move_pkg.sv
// How it works
// [RL1] long move: first word 0000 0000 0110 0010, later words open with 1111
// [RL2] long move source is frame pointer plus 7-bit unsigned offset, 14 bits
// [RL3] long move destination is a 14-bit literal from later words, 0 to 16383
// [RL4] source and destination of long move reach the whole 0000h..3FFFh space
// [RL5] software never names pc low byte or top-of-stack bytes as long destination
// [RL6] source on an indirect register yields zero, no indirect access made
// [RL7] long move: three cycles, decode, read source, write without dummy read
// [RL8] indexed-to-indexed: frame pointer plus offsets, first word bit 7 set
// [RL9] short move: 12-bit destination, lower 4096 bytes, first word bit 7 clear
// [RL10] no move touches the frame pointer or flags, only the destination byte
package idx_move_pkg;

	localparam int ADDR_W = 14;
	localparam int DATA_W = 8;
	localparam int WORD_W = 16;
	localparam int OFS_W = 7;

	// core instruction cycle: four system clocks of 50 ns each
	localparam int CLK_PERIOD_NS = 50;
	localparam int INSTR_CYCLE_NS = 200;
	localparam int Q_PHASES = INSTR_CYCLE_NS / CLK_PERIOD_NS;
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q2 = 2'h1;
	localparam logic [1:0] PH_Q4 = 2'h3;
	localparam logic [1:0] PH_LAST = 2'(Q_PHASES - 1);

	// opcodes
	localparam logic [15:0] OP_LONG_FIRST = 16'h0062;
	localparam logic [7:0] OP_SHORT_HI = 8'heb;
	localparam logic [3:0] OP_EXT_NIB = 4'hf;
	localparam int SS_SEL_BIT = 7;

	// long move second word layout: offset then destination top bits
	localparam int LONG_OFS_LSB = 2;
	localparam int LONG_FDHI_W = 2;
	localparam int FD_LO_W = 12;

	// indirect register window in the data space
	localparam logic [13:0] INDIRECT_BASE = 14'h3ee0;
	localparam logic [13:0] INDIRECT_MASK = 14'h3fe0;

	localparam logic [13:0] ADDR_RST = 14'h0000;
	localparam logic [7:0] DATA_RST = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LONG2 = 3'b001,
		ST_LONG3 = 3'b010,
		ST_SHORT2 = 3'b011,
		ST_SS2 = 3'b100
	} move_state_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic rd;
		logic wr;
		logic [DATA_W-1:0] wdata;
	} mem_req_type;

endpackage

// ===== rtl/indexed_move_execution.sv
`timescale 1ns/1ps
module indexed_move_execution
	import idx_move_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic instr_valid_i,
	input wire logic [WORD_W-1:0] instr_word_i,
	input wire logic [ADDR_W-1:0] frame_ptr_i,
	input wire logic [DATA_W-1:0] mem_rdata_i,
	output mem_req_type mem_req_o,
	output logic busy_o,
	output logic illegal_o,
	output logic word_taken_o
);
	// true when an address hits the indirect register window
	function automatic logic is_indirect(input logic [ADDR_W-1:0] a);
		return (a & INDIRECT_MASK) == INDIRECT_BASE;
	endfunction

	// frame pointer plus unsigned offset, wraps in the 14-bit space
	function automatic logic [ADDR_W-1:0] frame_add(input logic [ADDR_W-1:0] fp,
		input logic [OFS_W-1:0] ofs);
		return ADDR_W'(fp + {{(ADDR_W-OFS_W){1'b0}}, ofs});
	endfunction

	// quarter phase of the instruction cycle, restarts at Q1 on reset
	logic [1:0] phase;

	q_phase_gen u_phase (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.phase_o(phase)
	);

	// decode state and the access plan of the current instruction
	move_state_type state_reg, state_next;
	logic [ADDR_W-1:0] src_reg, src_next;
	logic [ADDR_W-1:0] dst_reg, dst_next;
	logic [1:0] fd_hi_reg, fd_hi_next;
	logic rd_q2_reg, rd_q2_next;
	logic rd_q4_reg, rd_q4_next;
	logic wr_q4_reg, wr_q4_next;
	logic busy_reg, busy_next;

	// read capture and the byte in flight
	logic cap_reg, cap_next;
	logic zero_src_reg, zero_src_next;
	logic [DATA_W-1:0] data_reg, data_next;

	// registered bus request and status pulses
	mem_req_type req_reg, req_next;
	logic illegal_reg, illegal_next;
	logic taken_reg, taken_next;

	// a word is taken only in Q1; valid in the other quarters is ignored
	logic take;
	logic ext_ok;
	assign take = instr_valid_i && (phase == PH_Q1);
	// extension words all open with the same nibble
	assign ext_ok = instr_word_i[WORD_W-1 -: 4] == OP_EXT_NIB; // RL1

	// decode: one word taken at the start of each instruction cycle
	always_comb begin
		state_next = state_reg;
		src_next = src_reg;
		dst_next = dst_reg;
		fd_hi_next = fd_hi_reg;
		rd_q2_next = rd_q2_reg;
		rd_q4_next = rd_q4_reg;
		wr_q4_next = wr_q4_reg;
		illegal_next = 1'b0;
		taken_next = take;
		// each planned access fires once, so a gap between words never repeats it
		if (phase == PH_Q2) begin
			rd_q2_next = 1'b0;
		end
		if (phase == PH_Q4) begin
			rd_q4_next = 1'b0;
			wr_q4_next = 1'b0; // RL7
		end
		if (take) begin
			rd_q2_next = 1'b0;
			rd_q4_next = 1'b0;
			wr_q4_next = 1'b0;
			// an instruction ends here unless its branch keeps it going
			state_next = ST_IDLE;
			case (state_reg)
				ST_IDLE: begin
					// other single-word codes belong to the rest of the core
					if (instr_word_i == OP_LONG_FIRST) begin
						state_next = ST_LONG2; // RL1 RL7 decode only
					end else if (instr_word_i[15:8] == OP_SHORT_HI) begin
						// source read in the fourth quarter of this cycle
						src_next = frame_add(frame_ptr_i, instr_word_i[OFS_W-1:0]); // RL8
						rd_q4_next = 1'b1;
						state_next = instr_word_i[SS_SEL_BIT] ? ST_SS2 : ST_SHORT2; // RL8 RL9
					end
				end
				ST_LONG2: begin
					if (ext_ok) begin
						// offset and top destination bits share this word
						src_next = frame_add(frame_ptr_i,
							instr_word_i[LONG_OFS_LSB +: OFS_W]); // RL2 RL4
						fd_hi_next = instr_word_i[LONG_FDHI_W-1:0];
						rd_q2_next = 1'b1; // RL7
						state_next = ST_LONG3;
					end else begin
						illegal_next = 1'b1;
					end
				end
				ST_LONG3: begin
					// last word: the read is done, the write waits for Q4
					if (ext_ok) begin
						dst_next = {fd_hi_reg, instr_word_i[FD_LO_W-1:0]}; // RL3 RL4
						wr_q4_next = 1'b1; // RL7 no dummy read
					end else begin
						illegal_next = 1'b1;
					end
				end
				ST_SHORT2: begin
					// 12 bits only, the top of the data space is out of reach
					if (ext_ok) begin
						dst_next = {2'b00, instr_word_i[FD_LO_W-1:0]}; // RL9
						wr_q4_next = 1'b1;
					end else begin
						illegal_next = 1'b1;
					end
				end
				ST_SS2: begin
					if (ext_ok) begin
						dst_next = frame_add(frame_ptr_i, instr_word_i[OFS_W-1:0]); // RL8
						// indirect destination turns the move into a no-op
						wr_q4_next = !is_indirect(dst_next);
					end else begin
						illegal_next = 1'b1;
					end
				end
				default: begin
					state_next = ST_IDLE;
				end
			endcase
		end
		// busy comes from a flop, the pin sees no decode after it
		busy_next = (state_next != ST_IDLE);
	end

	// decode registers
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= ST_IDLE;
			src_reg <= ADDR_RST;
			dst_reg <= ADDR_RST;
			fd_hi_reg <= 2'h0;
			rd_q2_reg <= 1'b0;
			rd_q4_reg <= 1'b0;
			wr_q4_reg <= 1'b0;
			illegal_reg <= 1'b0;
			taken_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			src_reg <= src_next;
			dst_reg <= dst_next;
			fd_hi_reg <= fd_hi_next;
			rd_q2_reg <= rd_q2_next;
			rd_q4_reg <= rd_q4_next;
			wr_q4_reg <= wr_q4_next;
			illegal_reg <= illegal_next;
			taken_reg <= taken_next;
			busy_reg <= busy_next;
		end
	end

	// data bus: read in its quarter, capture one clock later, write in Q4
	always_comb begin
		logic rd_now;
		// a planned read whose quarter has come
		rd_now = (rd_q2_reg && phase == PH_Q2) || (rd_q4_reg && phase == PH_Q4);
		req_next = '0;
		req_next.addr = req_reg.addr;
		cap_next = 1'b0;
		zero_src_next = zero_src_reg;
		data_next = data_reg;
		// read data stands only in the clock after rd, so take it there
		if (cap_reg) begin
			data_next = zero_src_reg ? DATA_RST : mem_rdata_i; // RL6
		end
		if (rd_now) begin
			req_next.addr = src_reg;
			// an indirect source is never touched on the bus
			req_next.rd = !is_indirect(src_reg); // RL6
			zero_src_next = is_indirect(src_reg); // RL6
			cap_next = 1'b1;
		end else if (wr_q4_reg && phase == PH_Q4) begin
			// reads win the bus; the plans never put both in one clock
			req_next.addr = dst_reg;
			req_next.wr = 1'b1; // RL10 only the destination byte changes
			req_next.wdata = data_reg;
		end
	end

	// bus registers
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			req_reg <= '0;
			cap_reg <= 1'b0;
			zero_src_reg <= 1'b0;
			data_reg <= DATA_RST;
		end else begin
			req_reg <= req_next;
			cap_reg <= cap_next;
			zero_src_reg <= zero_src_next;
			data_reg <= data_next;
		end
	end

	// outputs: all straight from flops
	assign mem_req_o = req_reg;
	assign busy_o = busy_reg;
	assign illegal_o = illegal_reg;
	assign word_taken_o = taken_reg;
endmodule // indexed_move_execution

// ===== rtl/q_phase_gen.sv
`timescale 1ns/1ps
module q_phase_gen
	import idx_move_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	output logic [1:0] phase_o
);
	logic [1:0] phase_reg;
	logic [1:0] phase_next;

	// free running phase count, wraps after the last quarter
	always_comb begin
		phase_next = (phase_reg == PH_LAST) ? PH_Q1 : phase_reg + 2'h1;
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			phase_reg <= PH_Q1;
		end else begin
			phase_reg <= phase_next;
		end
	end

	assign phase_o = phase_reg;
endmodule // q_phase_gen

// ===== verif/data_mem_model.sv
`timescale 1ns/1ps
module data_mem_model
	import idx_move_pkg::*;
(
	input wire logic sys_clk_i,
	input wire mem_req_type req_i,
	output logic [DATA_W-1:0] rdata_o
);
	logic [DATA_W-1:0] junk_reg = 8'h3c;
	// stale bus flips each clock so a late sample never looks right
	always @(posedge sys_clk_i) junk_reg <= ~junk_reg;
	// content is a fixed function of the address
	assign rdata_o = req_i.rd ? req_i.addr[7:0] ^ {2'h0, req_i.addr[13:8]} ^ 8'ha5 : junk_reg;
endmodule // data_mem_model

// ===== verif/idx_move_properties.sv
`timescale 1ns/1ps
module idx_move_checker
	import idx_move_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic instr_valid_i,
	input wire mem_req_type mem_req_o,
	input wire logic busy_o,
	input wire logic illegal_o,
	input wire logic word_taken_o
);
	logic [1:0] ph_reg;
	logic [1:0] ph_next;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	// own phase count, restarts with reset like the core's
	always_comb ph_next = ph_reg + 2'h1;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) ph_reg <= 2'h0;
		else ph_reg <= ph_next;
	end
	chk_no_overlap: assert property (!(mem_req_o.rd && mem_req_o.wr))
		else $error("read and write together");
	chk_read_phase: assert property (mem_req_o.rd |-> ph_reg == 2'h0 || ph_reg == 2'h2)
		else $error("read in wrong phase");
	chk_write_phase: assert property (mem_req_o.wr |-> ph_reg == 2'h0)
		else $error("write in wrong phase");
	chk_read_write_gap: assert property (mem_req_o.rd |=> !mem_req_o.wr [*3])
		else $error("write too soon after read");
	chk_indirect_read: assert property (mem_req_o.rd |-> (mem_req_o.addr & INDIRECT_MASK) != INDIRECT_BASE)
		else $error("indirect source read");
	chk_taken_cause: assert property (word_taken_o |-> $past(instr_valid_i) && ph_reg == 2'h1)
		else $error("word taken without cause");
	chk_illegal_idle: assert property (illegal_o |=> !busy_o [*3])
		else $error("busy after illegal word");
	chk_taken_pulse: assert property (word_taken_o |=> !word_taken_o)
		else $error("taken pulse too long");
	cov_write: cover property (mem_req_o.wr);
	cov_read: cover property (mem_req_o.rd);
	cov_illegal: cover property (illegal_o);
endmodule // idx_move_checker

bind indexed_move_execution idx_move_checker idx_move_checker_i (.sys_clk_i, .arst_n_i,
	.instr_valid_i, .mem_req_o, .busy_o, .illegal_o, .word_taken_o);

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	import idx_move_pkg::*;
	logic sys_clk_i = 0;
	logic arst_n_i = 0;
	logic vld = 0;
	logic [15:0] w = 16'h0000;
	logic [13:0] fp = 14'h0000;
	logic [7:0] rdat;
	mem_req_type req;
	logic busy, ill, taken;
	logic [21:0] q[$];
	int mismatches = 0, n_tests = 0, n_ill = 0, e_ill = 0, cyc = 0;
	int n_take = 0, e_take = 0;
	int seed = 32'h254f50a1;
	always #25 sys_clk_i = ~sys_clk_i;
	indexed_move_execution indexed_move_execution_i (.sys_clk_i, .arst_n_i, .instr_valid_i(vld),
		.instr_word_i(w), .frame_ptr_i(fp), .mem_rdata_i(rdat), .mem_req_o(req), .busy_o(busy),
		.illegal_o(ill), .word_taken_o(taken));
	data_mem_model data_mem_model_i (.sys_clk_i, .req_i(req), .rdata_o(rdat));
	task automatic final_report;
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// one word per instruction cycle, held over all four phases
	task automatic put(input logic [15:0] x);
		w = x;
		vld = 1;
		e_take++;
		repeat (4) @(posedge sys_clk_i);
		#5;
	endtask
	// indirect window reads back as zero
	function automatic logic [7:0] val(input logic [13:0] a);
		return (a & INDIRECT_MASK) == INDIRECT_BASE ? 8'h00 : a[7:0] ^ {2'h0, a[13:8]} ^ 8'ha5;
	endfunction
	// k: 0 long, 1 short, 2 indexed-to-indexed
	task automatic mv(input int k, input logic [6:0] zs, input logic [13:0] d);
		logic [13:0] dst;
		dst = k == 0 ? d : k == 1 ? {2'h0, d[11:0]} : fp + 14'(d[6:0]);
		if (!(k == 2 && (dst & INDIRECT_MASK) == INDIRECT_BASE)) q.push_back({dst, val(fp + 14'(zs))});
		if (k == 0) put(16'h0062);
		else put({8'heb, k == 2, zs});
		n_tests++;
		if (busy !== 1'b1) begin
			mismatches++;
			$display("MISMATCH busy expected 1 seen %b", busy);
		end
		if (k == 0) put({4'hf, 3'h0, zs, d[13:12]});
		put({4'hf, k == 2 ? {5'h0, d[6:0]} : d[11:0]});
	endtask
	// writes are matched against the oldest expectation
	always @(posedge sys_clk_i) begin
		cyc++;
		if (ill === 1'b1) n_ill++;
		if (taken === 1'b1) n_take++;
		if (req.wr === 1'b1) begin
			n_tests++;
			if (q.size() == 0 || {req.addr, req.wdata} !== q[0]) begin
				mismatches++;
				$display("MISMATCH write expected %h seen %h", q.size() ? q[0] : 22'h0, {req.addr, req.wdata});
			end
			if (q.size() != 0) void'(q.pop_front());
		end
		if (cyc > 4000) begin
			mismatches++;
			final_report;
		end
	end
	initial begin
		repeat (2) @(posedge sys_clk_i);
		#5;
		arst_n_i = 1;
		put(16'h0000);
		fp = 14'h3fff;
		mv(0, 7'h7f, 14'h3fff);
		fp = INDIRECT_BASE - 14'h5;
		mv(0, 7'h05, 14'h2000);
		// long move with a pause between words: no access may repeat
		fp = 14'h2080;
		q.push_back({14'h2000, val(14'h2085)});
		put(16'h0062);
		put(16'hf016);
		vld = 0;
		repeat (8) @(posedge sys_clk_i);
		#5;
		put(16'hf000);
		fp = 14'h2080;
		mv(1, 7'h05, 14'h0fff);
		mv(2, 7'h05, 14'h0006);
		fp = INDIRECT_BASE;
		mv(2, 7'h01, 14'h0000);
		put(16'heb85);
		e_ill = 1;
		put(16'h1234);
		// random destinations cover the whole data space, indirect window included
		repeat (50) begin
			fp = 14'($random(seed));
			mv($unsigned($random(seed)) % 3, 7'($random(seed)), 14'($random(seed)));
		end
		vld = 0;
		repeat (16) @(posedge sys_clk_i);
		n_tests++;
		if (q.size() != 0 || n_ill != e_ill) begin
			mismatches++;
			$display("MISMATCH left/illegal expected 0/%0d seen %0d/%0d", e_ill, q.size(), n_ill);
		end
		n_tests++;
		if (n_take != e_take || busy !== 1'b0) begin
			mismatches++;
			$display("MISMATCH taken/busy expected %0d/0 seen %0d/%b", e_take, n_take, busy);
		end
		final_report;
	end
endmodule // testbench
